/* design/pmr_control.sv */
// Power-mode and reset control: power register, Idle/Stop/Suspend and reset sequencing
// Functional notes
// - Writing stop bit enters Stop after the writing instruction retires.
// - Stop halts internal oscillator, CPU, digital peripherals; external oscillator untouched.
// - Only a reset ends Stop; then normal reset, fetch from 0x0000.
// - Enabled missing-clock detector resets out of Stop; software disables it first.
// - Writing suspend bit 5 halts CPU and fast oscillator after instruction retires.
// - Suspend keeps registers and memory; only port match logic stays active.
// - Suspend ends on port match, enabled comparator low, or any reset.
// - Non-reset wake resumes after suspend instruction, servicing wake interrupt first.
// - Power register bits 7:2 are read/write general flags, reset zero.
// - Stop and idle bits always read back as zero.
// - Idle gates only CPU clock; timers, interrupts, serial, analog keep running.
// - Reset halts execution, resets registers, forces ports, disables interrupts, timers.
// - Reset leaves data memory intact but restores stack pointer.
// - Reset loads port latches 0xFF open-drain with weak pull-ups on.
// - Power-on and supply-monitor resets drive reset pin low while in reset.
// - Reset exit clears PC, selects internal oscillator, enables watchdog at clk/12.
// - Power-up holds reset until supply good, then waits a further delay.
// - Power-on exit sets power-on flag; any other reset clears it.
// - Power-on reset leaves supply monitor enabled; data memory treated undefined.
// - Enabled interrupt during Idle clears idle bit and resumes the CPU.
`timescale 1ns/1ps
`include "pmr_params.svh"
module pmr_control #(
    parameter int POR_DELAY_CYCLES = `PMR_POR_DELAY_US * `PMR_CLK_MHZ,
    parameter int POR_W = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic supply_good,
    input wire logic ext_reset,
    input wire logic int_reset,
    input wire logic mcd_enable,
    input wire logic mcd_timeout,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic instr_retire,
    input wire logic suspend_write,
    input wire logic port_match,
    input wire logic comparator_out,
    input wire logic comparator_wake_en,
    input wire logic irq_pending,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic port_match_en,
    output logic int_osc_en,
    output logic ext_osc_hold,
    output logic cpu_reset,
    output logic [15:0] pc_load_value,
    output logic pc_load,
    output logic sfr_reset,
    output logic sp_reset,
    output logic ram_undefined,
    output logic [7:0] port_latch,
    output logic port_open_drain,
    output logic weak_pullup_en,
    output logic irq_disable,
    output logic sysclk_int_osc,
    output logic wdt_enable,
    output logic wdt_tick,
    output logic vdd_mon_force_en,
    output logic power_on_reset_flag,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    output logic wake_irq
);
    pmr_pkg::pmr_state_t state;
    pmr_pkg::pmr_state_t next_state;
    logic [5:0] general_flags;
    logic [5:0] next_general_flags;
    logic stop_req;
    logic next_stop_req;
    logic idle_req;
    logic next_idle_req;
    logic susp_req;
    logic next_susp_req;
    logic por_flag;
    logic next_por_flag;
    logic por_cause;
    logic next_por_cause;
    logic wdt_on;
    logic next_wdt_on;
    logic wake_pend;
    logic next_wake_pend;
    logic any_reset;
    logic power_control_wr;
    logic por_restart;
    logic por_done;
    logic mcd_reset;
    logic stop_strobe;
    logic idle_strobe;
    logic wake_event;

    // Missing-clock timeout only causes a reset when the detector is enabled
    assign mcd_reset = mcd_enable && mcd_timeout;
    assign any_reset = ext_reset || int_reset || mcd_reset;
    assign power_control_wr = sfr_wr && (sfr_addr == `PMR_POWER_CONTROL_ADDR);
    assign por_restart = !supply_good;

    // Select bits are decoded only as strobes of the current write
    assign stop_strobe = power_control_wr && sfr_wdata[`PMR_POWER_CONTROL_STOP_BIT];
    assign idle_strobe = power_control_wr && sfr_wdata[`PMR_POWER_CONTROL_IDLE_BIT];
    assign wake_event = port_match || (comparator_wake_en && !comparator_out);

    pmr_delay #(
        .CYCLES(POR_DELAY_CYCLES),
        .W(POR_W)
    ) u_por_delay (
        .clk(clk),
        .srst(srst),
        .restart(por_restart),
        .done(por_done)
    );

    // Prescaler only runs while the watchdog is on after reset exit
    pmr_wdt_div u_wdt_div (
        .clk(clk),
        .srst(srst),
        .enable(wdt_on),
        .tick(wdt_tick)
    );

    always_comb begin
        next_state = state;
        next_general_flags = general_flags;
        next_stop_req = stop_req;
        next_idle_req = idle_req;
        next_susp_req = susp_req;
        next_por_flag = por_flag;
        next_por_cause = por_cause;
        next_wdt_on = wdt_on;
        next_wake_pend = 1'b0;
        if (power_control_wr) begin
            next_general_flags = sfr_wdata[`PMR_GF_MSB:`PMR_GF_LSB];
            // Strobes only arm a pending entry; the bits themselves are never stored
            if (stop_strobe) begin
                next_stop_req = 1'b1;
            end
            if (idle_strobe) begin
                next_idle_req = 1'b1;
            end
        end
        if (suspend_write) begin
            next_susp_req = 1'b1;
        end
        case (state)
            pmr_pkg::PMR_RESET: begin
                next_stop_req = 1'b0;
                next_idle_req = 1'b0;
                next_susp_req = 1'b0;
                next_general_flags = `PMR_GF_RESET;
                next_wdt_on = 1'b0;
                // Non-supply resets skip the power-on delay
                if (!any_reset) begin
                    if (por_cause) begin
                        next_state = pmr_pkg::PMR_POR_WAIT;
                    end else begin
                        next_state = pmr_pkg::PMR_RUN;
                        next_por_flag = 1'b0;
                        next_wdt_on = 1'b1;
                    end
                end
            end
            pmr_pkg::PMR_POR_WAIT: begin
                next_stop_req = 1'b0;
                next_idle_req = 1'b0;
                next_susp_req = 1'b0;
                next_general_flags = `PMR_GF_RESET;
                // The delay restarts on every supply dip, so the full wait always follows
                if (!supply_good) begin
                    next_por_cause = 1'b1;
                end else if (por_done && !any_reset) begin
                    next_state = pmr_pkg::PMR_RUN;
                    next_por_flag = 1'b1;
                    next_por_cause = 1'b0;
                    next_wdt_on = 1'b1;
                end
            end
            pmr_pkg::PMR_RUN: begin
                // Entry waits for the writing instruction to retire
                // A strobe on the retiring edge still arms its request: the set wins
                if (instr_retire && stop_req) begin
                    next_state = pmr_pkg::PMR_STOP;
                    next_stop_req = stop_strobe;
                    next_idle_req = idle_strobe;
                end else if (instr_retire && susp_req) begin
                    next_state = pmr_pkg::PMR_SUSPEND;
                    next_susp_req = suspend_write;
                end else if (instr_retire && idle_req) begin
                    next_state = pmr_pkg::PMR_IDLE;
                end
            end
            pmr_pkg::PMR_IDLE: begin
                if (irq_pending) begin
                    next_idle_req = 1'b0;
                    next_state = pmr_pkg::PMR_RUN;
                end
            end
            pmr_pkg::PMR_STOP: begin
                // Wake sources are ignored here; only the reset override below exits
                next_state = pmr_pkg::PMR_STOP;
            end
            pmr_pkg::PMR_SUSPEND: begin
                if (wake_event) begin
                    next_state = pmr_pkg::PMR_RUN;
                    next_wake_pend = 1'b1;
                end
            end
            default: begin
                next_state = pmr_pkg::PMR_RESET;
            end
        endcase
        // Reset overrides every mode, Stop included
        if (!supply_good) begin
            next_state = pmr_pkg::PMR_POR_WAIT;
            next_por_cause = 1'b1;
            next_wdt_on = 1'b0;
        end else if (any_reset && state != pmr_pkg::PMR_POR_WAIT) begin
            next_state = pmr_pkg::PMR_RESET;
            next_wdt_on = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            // Power-up begins in the supply wait so the delay always runs first
            state <= pmr_pkg::PMR_POR_WAIT;
            general_flags <= `PMR_GF_RESET;
            stop_req <= 1'b0;
            idle_req <= 1'b0;
            susp_req <= 1'b0;
            por_flag <= 1'b0;
            por_cause <= 1'b1;
            wdt_on <= 1'b0;
            wake_pend <= 1'b0;
        end else begin
            state <= next_state;
            general_flags <= next_general_flags;
            stop_req <= next_stop_req;
            idle_req <= next_idle_req;
            susp_req <= next_susp_req;
            por_flag <= next_por_flag;
            por_cause <= next_por_cause;
            wdt_on <= next_wdt_on;
            wake_pend <= next_wake_pend;
        end
    end

    logic in_reset;
    assign in_reset = (state == pmr_pkg::PMR_RESET) || (state == pmr_pkg::PMR_POR_WAIT);

    // Register read: select bits read zero
    // Read data stands one cycle, then returns to zero
    assign sfr_hit = (sfr_wr || sfr_rd) && (sfr_addr == `PMR_POWER_CONTROL_ADDR);
    always_ff @(posedge clk) begin
        if (srst) begin
            sfr_rdata <= `PMR_POWER_CONTROL_RESET;
        end else if (sfr_rd && sfr_addr == `PMR_POWER_CONTROL_ADDR) begin
            sfr_rdata <= {general_flags, 2'h0};
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    // Clock gating per mode
    assign cpu_clk_en = (state == pmr_pkg::PMR_RUN);
    assign periph_clk_en = (state == pmr_pkg::PMR_RUN) || (state == pmr_pkg::PMR_IDLE);
    assign port_match_en = (state != pmr_pkg::PMR_STOP);
    assign int_osc_en = (state != pmr_pkg::PMR_STOP) && (state != pmr_pkg::PMR_SUSPEND);
    // External oscillator keeps its configured state in Stop
    assign ext_osc_hold = (state == pmr_pkg::PMR_STOP);

    // Reset-state effects; data memory itself is never cleared here
    assign cpu_reset = in_reset;
    assign sfr_reset = in_reset;
    assign sp_reset = in_reset;
    assign irq_disable = in_reset;
    assign port_latch = `PMR_PORT_RESET;
    assign port_open_drain = in_reset;
    assign weak_pullup_en = 1'b1;
    assign pc_load = in_reset;
    assign pc_load_value = `PMR_RESET_VECTOR;
    assign sysclk_int_osc = in_reset;
    assign wdt_enable = wdt_on;
    assign vdd_mon_force_en = (state == pmr_pkg::PMR_POR_WAIT);
    assign ram_undefined = por_flag;
    assign power_on_reset_flag = por_flag;
    assign wake_irq = wake_pend;

    // Pin pulled low only for supply-caused resets; released otherwise
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe_n = !(state == pmr_pkg::PMR_POR_WAIT);
endmodule // pmr_control

/* design/pmr_params.svh */
// Constants for the power-mode and reset controller
`ifndef PMR_PARAMS_SVH
`define PMR_PARAMS_SVH
`define PMR_POWER_CONTROL_ADDR 8'h87
`define PMR_POWER_CONTROL_RESET 8'h00
`define PMR_POWER_CONTROL_IDLE_BIT 0
`define PMR_POWER_CONTROL_STOP_BIT 1
`define PMR_GF_LSB 2
`define PMR_GF_MSB 7
`define PMR_GF_RESET 6'h00
`define PMR_SUSPEND_BIT 5
`define PMR_POWER_ON_RESET_FLAG_BIT 1
`define PMR_RESET_VECTOR 16'h0000
`define PMR_PORT_RESET 8'hFF
`define PMR_WDT_DIV 4'hC
`define PMR_CLK_MHZ 25
`define PMR_POR_DELAY_US 100
`define PMR_MCD_TIMEOUT_US 100
`endif

/* design/pmr_pkg.sv */
// Types for the power-mode and reset controller
package pmr_pkg;
    typedef enum logic [2:0] {
        PMR_RESET = 3'h0,
        PMR_POR_WAIT = 3'h1,
        PMR_RUN = 3'h2,
        PMR_IDLE = 3'h3,
        PMR_STOP = 3'h4,
        PMR_SUSPEND = 3'h5
    } pmr_state_t;
endpackage

/* design/pmr_delay.sv */
// Down counter that reports when a start-to-done delay has elapsed
`timescale 1ns/1ps
`include "pmr_params.svh"
module pmr_delay #(
    parameter int CYCLES = 2500,
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic restart,
    output logic done
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    always_comb begin
        next_count = count;
        if (restart) begin
            next_count = W'(CYCLES);
        end else if (count != '0) begin
            next_count = count - W'(1);
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            count <= W'(CYCLES);
        end else begin
            count <= next_count;
        end
    end
    assign done = (count == '0) && !restart;
endmodule // pmr_delay

/* design/pmr_wdt_div.sv */
// Prescaler producing one tick every DIV system clocks
`timescale 1ns/1ps
`include "pmr_params.svh"
module pmr_wdt_div #(
    parameter logic [3:0] DIV = `PMR_WDT_DIV
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic enable,
    output logic tick
);
    logic [3:0] count;
    logic [3:0] next_count;
    logic next_tick;
    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (enable) begin
            if (count == DIV - 4'h1) begin
                next_count = 4'h0;
                next_tick = 1'b1;
            end else begin
                next_count = count + 4'h1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            count <= 4'h0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule // pmr_wdt_div

/* test/pmr_cpu_model.sv */
// Core model: retires the writing instruction one cycle after each write strobe
`timescale 1ns/1ps
module pmr_cpu_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic sfr_wr,
    input wire logic suspend_write,
    output logic instr_retire
);
    always_ff @(posedge clk) begin
        instr_retire <= (sfr_wr || suspend_write) && !srst;
    end
endmodule // pmr_cpu_model

/* test/pmr_control_props.sv */
// Checker for the power-mode and reset controller ports
`timescale 1ns/1ps
module pmr_control_props (
    input wire logic clk,
    input wire logic srst,
    input wire logic supply_good,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic instr_retire,
    input wire logic port_match,
    input wire logic irq_pending,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic port_match_en,
    input wire logic int_osc_en,
    input wire logic cpu_reset,
    input wire logic [15:0] pc_load_value,
    input wire logic pc_load,
    input wire logic sfr_reset,
    input wire logic sp_reset,
    input wire logic [7:0] port_latch,
    input wire logic port_open_drain,
    input wire logic weak_pullup_en,
    input wire logic irq_disable,
    input wire logic wdt_enable,
    input wire logic wdt_tick,
    input wire logic power_on_reset_flag,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_n,
    input wire logic wake_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    mode_bits_zero_a: assert property (sfr_rd && sfr_addr == 8'h87 |=> sfr_rdata[1:0] == 2'h0)
        else $error("mode bits read nonzero");
    stop_entry_a: assert property (sfr_wr && sfr_addr == 8'h87 && sfr_wdata[1] && !cpu_reset
        ##1 instr_retire |-> ##[1:2] (!cpu_clk_en && !int_osc_en))
        else $error("stop not entered");
    stop_hold_a: assert property (!cpu_clk_en && !periph_clk_en && !port_match_en
        && !cpu_reset && supply_good |=> !cpu_clk_en)
        else $error("stop left without reset");
    reset_pin_a: assert property (!rst_pin_oe_n |-> cpu_reset && !rst_pin_out)
        else $error("reset pin driven outside reset");
    reset_state_a: assert property (cpu_reset |-> sfr_reset && sp_reset && irq_disable
        && pc_load && pc_load_value == 16'h0000 && port_latch == 8'hFF && port_open_drain)
        else $error("reset outputs wrong");
    pullup_on_a: assert property (weak_pullup_en)
        else $error("weak pullup off");
    por_flag_a: assert property ($rose(rst_pin_oe_n) |-> ##[0:2] power_on_reset_flag)
        else $error("power-on flag not set");
    wdt_exit_a: assert property ($fell(cpu_reset) |-> ##[0:2] wdt_enable)
        else $error("watchdog not enabled");
    wdt_gap_a: assert property (wdt_tick |=> (!wdt_tick) [*8])
        else $error("watchdog tick too close");
    idle_wake_a: assert property (!cpu_clk_en && periph_clk_en && !cpu_reset && irq_pending
        |-> ##[1:2] cpu_clk_en)
        else $error("idle not left on interrupt");
    susp_wake_a: assert property (!cpu_clk_en && !periph_clk_en && port_match_en
        && !cpu_reset && port_match
        |-> ##[1:2] (cpu_clk_en && wake_irq))
        else $error("suspend not left on match");
endmodule // pmr_control_props

/* test/tb.sv */
// Testbench for the power-mode and reset controller
`timescale 1ns/1ps
module tb;
    logic clk, srst, supply_good, ext_reset, int_reset, mcd_enable, mcd_timeout, sfr_wr, sfr_rd;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, port_latch;
    logic sfr_hit, instr_retire, suspend_write, port_match, comparator_out, comparator_wake_en;
    logic irq_pending, cpu_clk_en, periph_clk_en, port_match_en, int_osc_en, cpu_reset, pc_load;
    logic [15:0] pc_load_value;
    logic sfr_reset, sp_reset, port_open_drain, weak_pullup_en, irq_disable, wdt_enable;
    logic power_on_reset_flag, rst_pin_oe_n, wake_irq;
    logic ext_osc_hold, ram_undefined, sysclk_int_osc, vdd_mon_force_en;
    int bad_count, check_count;
    pmr_control #(.POR_DELAY_CYCLES(10)) DUT (.clk, .srst, .supply_good, .ext_reset, .int_reset,
        .mcd_enable, .mcd_timeout, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_hit,
        .instr_retire, .suspend_write, .port_match, .comparator_out, .comparator_wake_en,
        .irq_pending, .cpu_clk_en, .periph_clk_en, .port_match_en, .int_osc_en, .ext_osc_hold,
        .cpu_reset, .pc_load_value, .pc_load, .sfr_reset, .sp_reset, .ram_undefined,
        .port_latch, .port_open_drain, .weak_pullup_en, .irq_disable, .sysclk_int_osc,
        .wdt_enable, .wdt_tick(), .vdd_mon_force_en, .power_on_reset_flag, .rst_pin_out(),
        .rst_pin_oe_n, .wake_irq);
    pmr_cpu_model u_cpu (.clk, .srst, .sfr_wr, .suspend_write, .instr_retire);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_wr = 1'b1; sfr_addr = a; sfr_wdata = d;
        step(1);
        sfr_wr = 1'b0;
        step(3);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_rd = 1'b1; sfr_addr = a;
        #1;
        chk("register hit", {7'h00, a == 8'h87}, {7'h00, sfr_hit});
        step(1);
        sfr_rd = 1'b0;
        chk("read data", exp, sfr_rdata);
        step(1);
    endtask
    // Bounded wait for the reset sequence to finish
    task automatic leave_reset();
        int n;
        for (n = 0; n < 40 && cpu_reset !== 1'b0; n++) step(1);
        chk("reset done", 8'h00, {7'h00, cpu_reset});
        if (cpu_reset !== 1'b0) end_of_test();
        step(2);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        {ext_reset, int_reset, mcd_enable, mcd_timeout, sfr_wr, sfr_rd, suspend_write} = '0;
        {port_match, comparator_wake_en, irq_pending, sfr_addr, sfr_wdata} = '0;
        bad_count = 0; check_count = 0;
        supply_good = 1'b0; comparator_out = 1'b1; srst = 1'b1;
        step(20);
        srst = 1'b0;
        step(5);
        chk("reset pin oe", 8'h03, {5'h00, rst_pin_oe_n, vdd_mon_force_en, sysclk_int_osc});
        supply_good = 1'b1;
        step(8);
        chk("held in delay", 8'h01, {7'h00, cpu_reset});
        leave_reset();
        chk("por flag", 8'h03, {6'h00, power_on_reset_flag, ram_undefined});
        chk("wdt on", 8'h01, {7'h00, wdt_enable});
        rd(8'h87, 8'h00);
        wr(8'h87, 8'hFC);
        rd(8'h87, 8'hFC);
        rd(8'h88, 8'h00);
        $display("test power register done");
        wr(8'h87, 8'hA9);
        chk("idle clocks", 8'h01, {6'h00, cpu_clk_en, periph_clk_en});
        irq_pending = 1'b1;
        step(3);
        irq_pending = 1'b0;
        chk("idle wake", 8'h01, {7'h00, cpu_clk_en});
        rd(8'h87, 8'hA8);
        $display("test idle done");
        for (int w = 0; w < 2; w++) begin
            suspend_write = 1'b1;
            step(1);
            suspend_write = 1'b0;
            step(3);
            chk("suspend", 8'h01, {5'h00, cpu_clk_en, int_osc_en, port_match_en});
            if (w == 0) port_match = 1'b1;
            else {comparator_wake_en, comparator_out} = 2'h2;
            step(3);
            {port_match, comparator_wake_en, comparator_out} = 3'h1;
            chk("wake", 8'h01, {7'h00, cpu_clk_en});
        end
        rd(8'h87, 8'hA8);
        $display("test suspend done");
        for (int s = 0; s < 3; s++) begin
            wr(8'h87, 8'h02);
            chk("stop", 8'h08, {4'h0, ext_osc_hold, cpu_clk_en, int_osc_en, periph_clk_en});
            port_match = 1'b1; irq_pending = 1'b1; mcd_timeout = 1'b1;
            step(4);
            chk("stop kept", 8'h00, {6'h00, cpu_clk_en, cpu_reset});
            {port_match, irq_pending, mcd_timeout} = 3'h0;
            if (s == 0) ext_reset = 1'b1;
            else if (s == 1) {mcd_enable, mcd_timeout} = 2'h3;
            else int_reset = 1'b1;
            step(3);
            chk("in reset", 8'h07, {5'h00, cpu_reset, rst_pin_oe_n, sysclk_int_osc});
            chk("port latch", 8'hFF, port_latch);
            {ext_reset, int_reset, mcd_enable, mcd_timeout} = 4'h0;
            leave_reset();
            chk("por flag clear", 8'h00, {6'h00, power_on_reset_flag, ram_undefined});
            rd(8'h87, 8'h00);
        end
        $display("test stop done");
        supply_good = 1'b0;
        step(2);
        chk("supply loss", 8'h02, {6'h00, cpu_reset, rst_pin_oe_n});
        supply_good = 1'b1;
        leave_reset();
        chk("por again", 8'h03, {6'h00, power_on_reset_flag, ram_undefined});
        $display("test supply loss done");
        end_of_test();
    end
endmodule // tb
bind pmr_control pmr_control_props u_props (.clk, .srst, .supply_good, .sfr_wr, .sfr_rd,
    .sfr_addr, .sfr_wdata, .sfr_rdata, .instr_retire, .port_match, .irq_pending, .cpu_clk_en,
    .periph_clk_en, .port_match_en, .int_osc_en, .cpu_reset, .pc_load_value, .pc_load,
    .sfr_reset, .sp_reset, .port_latch, .port_open_drain, .weak_pullup_en, .irq_disable,
    .wdt_enable, .wdt_tick, .power_on_reset_flag, .rst_pin_out, .rst_pin_oe_n, .wake_irq);
